// >>> src/lane_cond_params.svh
// register indices, field positions, reset values and code tables of the lane conditioning bank
`ifndef LANE_COND_PARAMS_SVH
`define LANE_COND_PARAMS_SVH
// register indices; the byte address on the bus is four times the index
`define LCR_IDX_L1_OUT_CTL     8'h23
`define LCR_IDX_L1_INB_EQ      8'h24
`define LCR_IDX_L1_OUT_SWING   8'h25
`define LCR_IDX_L1_OUT_DEEMPH  8'h26
`define LCR_IDX_L1_INB_THRESH  8'h27
`define LCR_IDX_L0A_OUT_CTL    8'h2B
// reset values
`define LCR_RST_OUT_CTL        8'h00
`define LCR_RST_INB_EQ         8'h20
`define LCR_RST_OUT_SWING      8'h03
`define LCR_RST_OUT_DEEMPH     8'h03
`define LCR_RST_INB_THRESH     8'h00
// field positions
`define LCR_BIT_IDLE_AUTO      5
`define LCR_BIT_IDLE_SEL       4
`define LCR_BIT_RATE_AUTO      1
`define LCR_BIT_RATE_SEL       0
`define LCR_BIT_EQ_EN          5
`define LCR_BIT_DEEMPH_TYPE    7
// output swing codes and their levels in mV
`define LCR_SWING_600          7'h03
`define LCR_SWING_800          7'h07
`define LCR_SWING_1000         7'h0F
`define LCR_SWING_1200         7'h1F
`define LCR_SWING_RSVD         7'h3F
`define LCR_MV_600             11'h258
`define LCR_MV_800             11'h320
`define LCR_MV_1000            11'h3E8
`define LCR_MV_1200            11'h4B0
// de-emphasis codes and their levels in tenths of a dB, two's complement
`define LCR_DEEMPH_0P0         8'h01
`define LCR_DEEMPH_3P5         8'hE8
`define LCR_DEEMPH_6P0         8'h88
`define LCR_DEEMPH_9P0         8'h90
`define LCR_DEEMPH_12P0        8'hA0
`define LCR_DB_0P0             8'h00
`define LCR_DB_M3P5            8'hDD
`define LCR_DB_M6P0            8'hC4
`define LCR_DB_M9P0            8'hA6
`define LCR_DB_M12P0           8'h88
// idle detector thresholds in mV
`define LCR_MV_70              8'h46
`define LCR_MV_110             8'h6E
`define LCR_MV_130             8'h82
`define LCR_MV_150             8'h96
`define LCR_MV_170             8'hAA
`define LCR_MV_190             8'hBE
// number of equalizer levels
`define LCR_EQ_LEVELS          5'h18
// avalon response codes
`define LCR_RESP_OKAY          2'h0
`define LCR_RESP_SLVERR        2'h2
`endif

// >>> src/lane_cond_pkg.sv
// types shared by the lane conditioning register bank
package lane_cond_pkg;
  typedef enum logic [1:0] {
    SQ_DRIVE  = 2'b00,
    SQ_MUTED  = 2'b01,
    SQ_AUTO   = 2'b10
  } squelch_mode_type;

  typedef enum logic [0:0] {
    DEEMPH_COMPAT   = 1'b0,
    DEEMPH_ENHANCED = 1'b1
  } deemph_kind_type;
endpackage

// >>> src/lane_conditioning_config_regs.sv
// configuration byte registers and decoded conditioning controls for two lanes
//
// Function
// - idle-auto bit selects automatic or manual squelch
// - manual idle-select zero keeps output driving
// - manual idle-select one mutes output to idle
// - rate-auto bit selects detected or manual rate
// - manual rate-select: 0 low range, 1 high
// - equalizer offers 24 levels, three stages
// - eq enable bit5, gain 4:3, boost 2:0
// - eq code 20h is bypass and default
// - swing codes map 600 to 1200 mV
// - de-emphasis bit7 type, bits 6:0 level
// - de-emphasis codes map 0 to -12 dB
// - threshold bits 3:2 deassert, 1:0 assert
// - threshold codes select millivolt pairs
`timescale 1ns/1ps
`include "lane_cond_params.svh"

module lane_conditioning_config_regs (
  // clock and reset
  input  wire logic                         I_CLOCK,
  input  wire logic                         I_RST,
  // avalon-mm slave
  input  wire logic [7:0]                   I_AVS_ADDRESS,
  input  wire logic                         I_AVS_READ,
  input  wire logic                         I_AVS_WRITE,
  input  wire logic [3:0]                   I_AVS_BYTEENABLE,
  input  wire logic [31:0]                  I_AVS_WRITEDATA,
  output logic      [31:0]                  O_AVS_READDATA,
  output logic                              O_AVS_WAITREQUEST,
  output logic      [1:0]                   O_AVS_RESPONSE,
  // analog detectors, asynchronous
  input  wire logic                         I_L1_OUT_IDLE_DET,
  input  wire logic                         I_L1_OUT_RATE_DET_HIGH,
  input  wire logic                         I_L0A_OUT_IDLE_DET,
  input  wire logic                         I_L0A_OUT_RATE_DET_HIGH,
  // lane1 common output: squelch and rate
  output lane_cond_pkg::squelch_mode_type   O_L1_OUT_SQUELCH_MODE,
  output logic                              O_L1_OUT_MUTE,
  output logic                              O_L1_OUT_RATE_AUTO,
  output logic                              O_L1_OUT_RATE_HIGH,
  // lane1 common output: swing and de-emphasis
  output logic      [6:0]                   O_L1_OUT_SWING_CODE,
  output logic      [10:0]                  O_L1_OUT_SWING_MV,
  output logic                              O_L1_OUT_SWING_VALID,
  output lane_cond_pkg::deemph_kind_type    O_L1_OUT_DEEMPH_KIND,
  output logic      [6:0]                   O_L1_OUT_DEEMPH_LEVEL,
  output logic      [7:0]                   O_L1_OUT_DEEMPH_DB_X10,
  output logic                              O_L1_OUT_DEEMPH_VALID,
  // lane1 side-b input: equalizer and idle thresholds
  output logic                              O_L1_INB_EQ_ENABLE,
  output logic      [1:0]                   O_L1_INB_GAIN_STAGE,
  output logic      [2:0]                   O_L1_INB_BOOST_LEVEL,
  output logic                              O_L1_INB_EQ_ACTIVE,
  output logic      [4:0]                   O_L1_INB_EQ_INDEX,
  output logic      [7:0]                   O_L1_INB_DEASSERT_MV,
  output logic      [7:0]                   O_L1_INB_ASSERT_MV,
  // lane0 side-a output: squelch and rate
  output lane_cond_pkg::squelch_mode_type   O_L0A_OUT_SQUELCH_MODE,
  output logic                              O_L0A_OUT_MUTE,
  output logic                              O_L0A_OUT_RATE_AUTO,
  output logic                              O_L0A_OUT_RATE_HIGH
);
  import lane_cond_pkg::*;
  localparam int NUM_REGS = 6;

  //////////////////////////////////////////////////////////////////////////////
  // register map helpers
  function automatic logic [7:0] reg_index(input int n);
    unique case (n)
      0:       reg_index = `LCR_IDX_L1_OUT_CTL;
      1:       reg_index = `LCR_IDX_L1_INB_EQ;
      2:       reg_index = `LCR_IDX_L1_OUT_SWING;
      3:       reg_index = `LCR_IDX_L1_OUT_DEEMPH;
      4:       reg_index = `LCR_IDX_L1_INB_THRESH;
      default: reg_index = `LCR_IDX_L0A_OUT_CTL;
    endcase
  endfunction

  function automatic logic [7:0] reg_reset(input int n);
    unique case (n)
      1:       reg_reset = `LCR_RST_INB_EQ;
      2:       reg_reset = `LCR_RST_OUT_SWING;
      3:       reg_reset = `LCR_RST_OUT_DEEMPH;
      4:       reg_reset = `LCR_RST_INB_THRESH;
      default: reg_reset = `LCR_RST_OUT_CTL;
    endcase
  endfunction

  // squelch mode of one output from its control byte
  function automatic squelch_mode_type squelch_mode(input logic [7:0] ctl);
    if (ctl[`LCR_BIT_IDLE_AUTO]) begin
      squelch_mode = SQ_AUTO;
    end else if (ctl[`LCR_BIT_IDLE_SEL]) begin
      squelch_mode = SQ_MUTED;
    end else begin
      squelch_mode = SQ_DRIVE;
    end
  endfunction

  // millivolt figure of one two-bit idle threshold code
  function automatic logic [7:0] thresh_mv(input logic [1:0] code, input logic deassert);
    unique case (code)
      2'b00: thresh_mv = deassert ? `LCR_MV_110 : `LCR_MV_70;
      2'b01: thresh_mv = deassert ? `LCR_MV_150 : `LCR_MV_110;
      2'b10: thresh_mv = deassert ? `LCR_MV_170 : `LCR_MV_130;
      2'b11: thresh_mv = deassert ? `LCR_MV_190 : `LCR_MV_150;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // detector synchronisers
  logic [3:0] det_async;
  logic [3:0] det_meta_q;
  logic [3:0] det_sync_q;

  assign det_async = {I_L0A_OUT_RATE_DET_HIGH, I_L0A_OUT_IDLE_DET,
                      I_L1_OUT_RATE_DET_HIGH, I_L1_OUT_IDLE_DET};

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      det_meta_q <= 4'h0;
      det_sync_q <= 4'h0;
    end else begin
      det_meta_q <= det_async;
      det_sync_q <= det_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait state per access
  logic                  ack_q;
  logic                  req;
  logic                  accept;
  logic [NUM_REGS-1:0]   sel;
  logic                  hit;
  logic [7:0]            rd_byte;
  logic [7:0]            regs_q [NUM_REGS];
  logic [31:0]           readdata_q;
  logic [1:0]            response_q;
  assign req               = I_AVS_READ | I_AVS_WRITE;
  assign accept            = req & ack_q;
  assign O_AVS_WAITREQUEST = req & ~ack_q;
  assign hit               = |sel;
  assign O_AVS_READDATA    = readdata_q;
  assign O_AVS_RESPONSE    = response_q;

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      logic [7:0] idx;
      assign idx    = reg_index(g);
      assign sel[g] = (I_AVS_ADDRESS == {idx[5:0], 2'b00});

      // reserved bits are stored as written; software keeps them zero
      always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
          regs_q[g] <= reg_reset(g);
        end else if (accept && I_AVS_WRITE && I_AVS_BYTEENABLE[0] && sel[g]) begin
          regs_q[g] <= I_AVS_WRITEDATA[7:0];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_byte = 8'h00;
    for (int n = 0; n < NUM_REGS; n++) begin
      rd_byte = rd_byte | (sel[n] ? regs_q[n] : 8'h00);
    end
  end

  // read data is captured in the wait cycle so it stands at the accepting edge
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      ack_q      <= 1'b0;
      readdata_q <= 32'h0000_0000;
      response_q <= `LCR_RESP_OKAY;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) begin
        readdata_q <= {24'h00_0000, rd_byte};
        response_q <= hit ? `LCR_RESP_OKAY : `LCR_RESP_SLVERR;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // field decode
  logic [7:0]  l1_ctl;
  logic [7:0]  l0a_ctl;
  logic [5:0]  eq_field;
  logic [6:0]  swing_code;
  logic [7:0]  deemph_byte;
  logic [3:0]  thresh_field;
  logic        eq_active;
  logic [4:0]  eq_index;
  logic [10:0] swing_mv;
  logic        swing_valid;
  logic [7:0]  deemph_db;
  logic        deemph_valid;

  assign l1_ctl       = regs_q[0];
  assign eq_field     = regs_q[1][5:0];
  assign swing_code   = regs_q[2][6:0];
  assign deemph_byte  = regs_q[3];
  assign thresh_field = regs_q[4][3:0];
  assign l0a_ctl      = regs_q[5];

  // stage 00 with enable set is bypass; stages 01..11 carry eight boosts each
  assign eq_active = eq_field[`LCR_BIT_EQ_EN] & (eq_field[4:3] != 2'b00);
  assign eq_index  = {2'(eq_field[4:3] - 2'b01), eq_field[2:0]};

  // only the listed codes carry a figure; the reserved code and others flag invalid
  always_comb begin
    swing_valid = 1'b1;
    unique case (swing_code)
      `LCR_SWING_600:  swing_mv = `LCR_MV_600;
      `LCR_SWING_800:  swing_mv = `LCR_MV_800;
      `LCR_SWING_1000: swing_mv = `LCR_MV_1000;
      `LCR_SWING_1200: swing_mv = `LCR_MV_1200;
      default: begin
        swing_mv    = 11'h000;
        swing_valid = 1'b0;
      end
    endcase
  end

  always_comb begin
    deemph_valid = 1'b1;
    unique case (deemph_byte)
      `LCR_DEEMPH_0P0:  deemph_db = `LCR_DB_0P0;
      `LCR_DEEMPH_3P5:  deemph_db = `LCR_DB_M3P5;
      `LCR_DEEMPH_6P0:  deemph_db = `LCR_DB_M6P0;
      `LCR_DEEMPH_9P0:  deemph_db = `LCR_DB_M9P0;
      `LCR_DEEMPH_12P0: deemph_db = `LCR_DB_M12P0;
      default: begin
        deemph_db    = 8'h00;
        deemph_valid = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered controls toward the analog circuits, one cycle after a write
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_L1_OUT_SQUELCH_MODE  <= SQ_DRIVE;
      O_L1_OUT_MUTE          <= 1'b0;
      O_L1_OUT_RATE_AUTO     <= 1'b0;
      O_L1_OUT_RATE_HIGH     <= 1'b0;
      O_L0A_OUT_SQUELCH_MODE <= SQ_DRIVE;
      O_L0A_OUT_MUTE         <= 1'b0;
      O_L0A_OUT_RATE_AUTO    <= 1'b0;
      O_L0A_OUT_RATE_HIGH    <= 1'b0;
    end else begin
      O_L1_OUT_SQUELCH_MODE  <= squelch_mode(l1_ctl);
      O_L1_OUT_MUTE          <= l1_ctl[`LCR_BIT_IDLE_AUTO] ? det_sync_q[0]
                                : l1_ctl[`LCR_BIT_IDLE_SEL];
      O_L1_OUT_RATE_AUTO     <= l1_ctl[`LCR_BIT_RATE_AUTO];
      O_L1_OUT_RATE_HIGH     <= l1_ctl[`LCR_BIT_RATE_AUTO] ? det_sync_q[1]
                                : l1_ctl[`LCR_BIT_RATE_SEL];
      O_L0A_OUT_SQUELCH_MODE <= squelch_mode(l0a_ctl);
      O_L0A_OUT_MUTE         <= l0a_ctl[`LCR_BIT_IDLE_AUTO] ? det_sync_q[2]
                                : l0a_ctl[`LCR_BIT_IDLE_SEL];
      O_L0A_OUT_RATE_AUTO    <= l0a_ctl[`LCR_BIT_RATE_AUTO];
      O_L0A_OUT_RATE_HIGH    <= l0a_ctl[`LCR_BIT_RATE_AUTO] ? det_sync_q[3]
                                : l0a_ctl[`LCR_BIT_RATE_SEL];
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_L1_OUT_SWING_CODE    <= 7'(`LCR_RST_OUT_SWING);
      O_L1_OUT_SWING_MV      <= `LCR_MV_600;
      O_L1_OUT_SWING_VALID   <= 1'b1;
      O_L1_OUT_DEEMPH_KIND   <= DEEMPH_COMPAT;
      O_L1_OUT_DEEMPH_LEVEL  <= 7'(`LCR_RST_OUT_DEEMPH);
      O_L1_OUT_DEEMPH_DB_X10 <= 8'h00;
      O_L1_OUT_DEEMPH_VALID  <= 1'b0;
    end else begin
      O_L1_OUT_SWING_CODE    <= swing_code;
      O_L1_OUT_SWING_MV      <= swing_mv;
      O_L1_OUT_SWING_VALID   <= swing_valid;
      O_L1_OUT_DEEMPH_KIND   <= deemph_kind_type'(deemph_byte[`LCR_BIT_DEEMPH_TYPE]);
      O_L1_OUT_DEEMPH_LEVEL  <= deemph_byte[6:0];
      O_L1_OUT_DEEMPH_DB_X10 <= deemph_db;
      O_L1_OUT_DEEMPH_VALID  <= deemph_valid;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_L1_INB_EQ_ENABLE   <= 1'b1;
      O_L1_INB_GAIN_STAGE  <= 2'h0;
      O_L1_INB_BOOST_LEVEL <= 3'h0;
      O_L1_INB_EQ_ACTIVE   <= 1'b0;
      O_L1_INB_EQ_INDEX    <= 5'h00;
      O_L1_INB_DEASSERT_MV <= `LCR_MV_110;
      O_L1_INB_ASSERT_MV   <= `LCR_MV_70;
    end else begin
      O_L1_INB_EQ_ENABLE   <= eq_field[`LCR_BIT_EQ_EN];
      O_L1_INB_GAIN_STAGE  <= eq_field[4:3];
      O_L1_INB_BOOST_LEVEL <= eq_field[2:0];
      O_L1_INB_EQ_ACTIVE   <= eq_active;
      O_L1_INB_EQ_INDEX    <= eq_active ? eq_index : 5'h00;
      O_L1_INB_DEASSERT_MV <= thresh_mv(thresh_field[3:2], 1'b1);
      O_L1_INB_ASSERT_MV   <= thresh_mv(thresh_field[1:0], 1'b0);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  a_bus_one_wait: assert property (
    (req && !ack_q) ##1 req |-> !O_AVS_WAITREQUEST ##1 (!req || O_AVS_WAITREQUEST))
    else $error("access not granted after exactly one wait cycle");
  a_write_lands: assert property (
    accept && I_AVS_WRITE && I_AVS_BYTEENABLE[0] && sel[0]
    |=> regs_q[0] == $past(I_AVS_WRITEDATA[7:0]))
    else $error("written byte not stored");
  a_read_returns: assert property (
    accept && I_AVS_READ && sel[1] |-> O_AVS_READDATA == {24'h00_0000, regs_q[1]})
    else $error("read data differs from register");
  a_idle_auto_mute: assert property (
    l1_ctl[`LCR_BIT_IDLE_AUTO] |=> O_L1_OUT_MUTE == $past(det_sync_q[0]))
    else $error("automatic squelch ignores detector");
  a_manual_drive_on: assert property (
    !l0a_ctl[`LCR_BIT_IDLE_AUTO] && !l0a_ctl[`LCR_BIT_IDLE_SEL]
    |=> !O_L0A_OUT_MUTE && O_L0A_OUT_SQUELCH_MODE == SQ_DRIVE)
    else $error("manual drive still muted");
  a_manual_mute_on: assert property (
    !l1_ctl[`LCR_BIT_IDLE_AUTO] && l1_ctl[`LCR_BIT_IDLE_SEL] |=> O_L1_OUT_MUTE)
    else $error("manual mute not applied");
  a_rate_manual_sel: assert property (
    !l1_ctl[`LCR_BIT_RATE_AUTO] |=> O_L1_OUT_RATE_HIGH == $past(l1_ctl[`LCR_BIT_RATE_SEL]))
    else $error("manual rate select not followed");
  a_eq_index_range: assert property (
    O_L1_INB_EQ_ACTIVE |-> O_L1_INB_EQ_INDEX < `LCR_EQ_LEVELS)
    else $error("equalizer index out of range");
  a_eq_fields_split: assert property (
    1'b1 |=> O_L1_INB_GAIN_STAGE == $past(eq_field[4:3])
             && O_L1_INB_BOOST_LEVEL == $past(eq_field[2:0]))
    else $error("equalizer fields misrouted");
  a_eq_reset_bypass: assert property (
    $past(I_RST) |-> regs_q[1] == `LCR_RST_INB_EQ)
    else $error("equalizer not bypass after reset");
  a_swing_top_level: assert property (
    swing_code == `LCR_SWING_1200 |=> O_L1_OUT_SWING_MV == `LCR_MV_1200 && O_L1_OUT_SWING_VALID)
    else $error("swing 1200 mV code misdecoded");
  a_deemph_max_level: assert property (
    deemph_byte == `LCR_DEEMPH_12P0 |=> O_L1_OUT_DEEMPH_DB_X10 == `LCR_DB_M12P0
                                        && O_L1_OUT_DEEMPH_KIND == DEEMPH_ENHANCED)
    else $error("de-emphasis -12 dB misdecoded");
  a_thresh_top_pair: assert property (
    thresh_field == 4'hF |=> O_L1_INB_DEASSERT_MV == `LCR_MV_190
                             && O_L1_INB_ASSERT_MV == `LCR_MV_150)
    else $error("idle threshold pair misdecoded");
  c_write_read: cover property (accept && I_AVS_WRITE ##[1:8] accept && I_AVS_READ);
  c_auto_idle: cover property (l1_ctl[`LCR_BIT_IDLE_AUTO] && det_sync_q[0] ##1 O_L1_OUT_MUTE);
  c_eq_max: cover property (O_L1_INB_EQ_ACTIVE && O_L1_INB_EQ_INDEX == 5'h17);
  c_unmapped: cover property (accept && !hit);
endmodule

// >>> tb/lane_conditioning_config_regs_tb.sv
// self-checking testbench of the lane conditioning configuration registers
`timescale 1ns/1ps
`include "lane_cond_params.svh"

module lane_conditioning_config_regs_tb;
  import lane_cond_pkg::*;

  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       avs_address = 8'h00;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [3:0]       avs_byteenable = 4'h0;
  logic [31:0]      avs_writedata = 32'h0;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic [1:0]       avs_response;
  logic             l1_idle_det = 1'b0;
  logic             l1_rate_det = 1'b0;
  logic             l0_idle_det = 1'b0;
  logic             l0_rate_det = 1'b0;
  squelch_mode_type l1_mode;
  squelch_mode_type l0_mode;
  deemph_kind_type  dm_kind;
  logic             l1_mute, l1_rauto, l1_rhigh, l0_mute, l0_rauto, l0_rhigh;
  logic [6:0]       sw_code, dm_level;
  logic [10:0]      sw_mv;
  logic             sw_valid, dm_valid, eq_en, eq_act;
  logic [7:0]       dm_db, th_de, th_as;
  logic [1:0]       eq_stage;
  logic [2:0]       eq_boost;
  logic [4:0]       eq_idx;
  int               errors = 0;
  int               compares = 0;
  logic [15:0]      lfsr_q = 16'h0004;
  logic [7:0]       mdl [6];

  localparam logic [7:0] IDX_TAB [6] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2B};
  localparam logic [7:0] MASK_TAB [6] = '{8'h33, 8'h3F, 8'h7F, 8'hFF, 8'h0F, 8'h33};
  localparam logic [7:0] RST_TAB [6] = '{8'h00, 8'h20, 8'h03, 8'h03, 8'h00, 8'h00};
  // upper nibble is the register slot, low byte the code
  localparam logic [11:0] CORNER [42] = '{
    12'h010, 12'h020, 12'h030, 12'h001, 12'h002, 12'h003, 12'h033,
    12'h120, 12'h12A, 12'h130, 12'h132, 12'h139, 12'h135, 12'h137, 12'h13B,
    12'h13D, 12'h118, 12'h100, 12'h13F,
    12'h203, 12'h207, 12'h20F, 12'h21F, 12'h23F, 12'h200,
    12'h301, 12'h3E8, 12'h388, 12'h390, 12'h3A0, 12'h303,
    12'h400, 12'h405, 12'h40A, 12'h40F, 12'h406, 12'h409,
    12'h510, 12'h520, 12'h503, 12'h533, 12'h500};

  always #12.5 clk = ~clk;

  lane_conditioning_config_regs u_dut (
    .I_CLOCK(clk), .I_RST(rst),
    .I_AVS_ADDRESS(avs_address), .I_AVS_READ(avs_read), .I_AVS_WRITE(avs_write),
    .I_AVS_BYTEENABLE(avs_byteenable), .I_AVS_WRITEDATA(avs_writedata),
    .O_AVS_READDATA(avs_readdata), .O_AVS_WAITREQUEST(avs_waitrequest),
    .O_AVS_RESPONSE(avs_response),
    .I_L1_OUT_IDLE_DET(l1_idle_det), .I_L1_OUT_RATE_DET_HIGH(l1_rate_det),
    .I_L0A_OUT_IDLE_DET(l0_idle_det), .I_L0A_OUT_RATE_DET_HIGH(l0_rate_det),
    .O_L1_OUT_SQUELCH_MODE(l1_mode), .O_L1_OUT_MUTE(l1_mute),
    .O_L1_OUT_RATE_AUTO(l1_rauto), .O_L1_OUT_RATE_HIGH(l1_rhigh),
    .O_L1_OUT_SWING_CODE(sw_code), .O_L1_OUT_SWING_MV(sw_mv),
    .O_L1_OUT_SWING_VALID(sw_valid), .O_L1_OUT_DEEMPH_KIND(dm_kind),
    .O_L1_OUT_DEEMPH_LEVEL(dm_level), .O_L1_OUT_DEEMPH_DB_X10(dm_db),
    .O_L1_OUT_DEEMPH_VALID(dm_valid), .O_L1_INB_EQ_ENABLE(eq_en),
    .O_L1_INB_GAIN_STAGE(eq_stage), .O_L1_INB_BOOST_LEVEL(eq_boost),
    .O_L1_INB_EQ_ACTIVE(eq_act), .O_L1_INB_EQ_INDEX(eq_idx),
    .O_L1_INB_DEASSERT_MV(th_de), .O_L1_INB_ASSERT_MV(th_as),
    .O_L0A_OUT_SQUELCH_MODE(l0_mode), .O_L0A_OUT_MUTE(l0_mute),
    .O_L0A_OUT_RATE_AUTO(l0_rauto), .O_L0A_OUT_RATE_HIGH(l0_rhigh));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic squelch_mode_type exp_mode(input logic [7:0] m);
    return m[5] ? SQ_AUTO : (m[4] ? SQ_MUTED : SQ_DRIVE);
  endfunction

  function automatic logic [11:0] exp_swing(input logic [6:0] c);
    case (c)
      7'h03: return {1'b1, 11'h258};
      7'h07: return {1'b1, 11'h320};
      7'h0F: return {1'b1, 11'h3E8};
      7'h1F: return {1'b1, 11'h4B0};
      default: return 12'h000;
    endcase
  endfunction

  // valid flag above signed tenths of a dB
  function automatic logic [8:0] exp_deemph(input logic [7:0] c);
    case (c)
      8'h01: return 9'h100;
      8'hE8: return 9'h1DD;
      8'h88: return 9'h1C4;
      8'h90: return 9'h1A6;
      8'hA0: return 9'h188;
      default: return 9'h000;
    endcase
  endfunction

  function automatic logic [4:0] exp_index(input logic [7:0] m);
    if (!m[5] || m[4:3] == 2'h0) return 5'h00;
    return 5'({m[4:3] - 2'h1, 3'h0}) + 5'(m[2:0]);
  endfunction

  function automatic logic [15:0] exp_thresh(input logic [1:0] c);
    case (c)
      2'h0: return 16'h6E46;
      2'h1: return 16'h966E;
      2'h2: return 16'hAA82;
      default: return 16'hBE96;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bus(input logic [31:0] rd, input logic [1:0] rs,
                         input logic [31:0] erd, input logic [1:0] ers);
    compares++;
    if (rd !== erd || rs !== ers) begin
      errors++;
      $display("ERROR t=%0t got=%h/%h exp=%h/%h", $time, rd, rs, erd, ers);
    end
  endtask

  // values read right after a rising edge are the ones that stood at it,
  // so waitrequest and read data are taken at the accepting edge itself
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
    int   n;
    logic w;
    n = 0;
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_byteenable <= be;
    avs_writedata  <= d;
    do begin
      @(posedge clk);
      w  = avs_waitrequest;
      rd = avs_readdata;
      rs = avs_response;
      n++;
    end while (w && n < 16);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (w) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic reg_write(input int k, input logic [7:0] v);
    logic [31:0] rd;
    logic [1:0]  rs;
    bus_xfer(1'b1, {IDX_TAB[k][5:0], 2'b00}, {lfsr_q, 8'h5A, v}, 4'h1, rd, rs);
    mdl[k] = v;
  endtask

  task automatic check_all;
    logic [31:0] rd;
    logic [1:0]  rs;
    for (int k = 0; k < 6; k++) begin
      bus_xfer(1'b0, {IDX_TAB[k][5:0], 2'b00}, 32'h0, 4'hF, rd, rs);
      chk_bus(rd, rs, {24'h0, mdl[k]}, 2'h0);
    end
    repeat (4) @(negedge clk);
    chk(l1_mode, exp_mode(mdl[0]));
    chk(l1_mute, mdl[0][5] ? l1_idle_det : mdl[0][4]);
    chk(l1_rauto, mdl[0][1]);
    chk(l1_rhigh, mdl[0][1] ? l1_rate_det : mdl[0][0]);
    chk(l0_mode, exp_mode(mdl[5]));
    chk(l0_mute, mdl[5][5] ? l0_idle_det : mdl[5][4]);
    chk(l0_rauto, mdl[5][1]);
    chk(l0_rhigh, mdl[5][1] ? l0_rate_det : mdl[5][0]);
    chk({eq_en, eq_stage, eq_boost}, mdl[1][5:0]);
    chk(eq_act, mdl[1][5] && mdl[1][4:3] != 2'h0);
    chk(eq_idx, exp_index(mdl[1]));
    chk({sw_valid, sw_mv}, exp_swing(mdl[2][6:0]));
    chk(sw_code, mdl[2][6:0]);
    chk({dm_kind, dm_level}, mdl[3]);
    chk({dm_valid, dm_db}, exp_deemph(mdl[3]));
    chk(th_de, exp_thresh(mdl[4][3:2]) >> 8);
    chk(th_as, exp_thresh(mdl[4][1:0]) & 16'h00FF);
  endtask

  task automatic new_dets;
    lfsr_q = lfsr_next(lfsr_q);
    @(posedge clk);
    l1_idle_det <= lfsr_q[0];
    l1_rate_det <= lfsr_q[3];
    l0_idle_det <= lfsr_q[5];
    l0_rate_det <= lfsr_q[9];
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    logic [1:0]  rs;
    int          k;
    foreach (mdl[j]) mdl[j] = RST_TAB[j];
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    check_all();
    for (int j = 0; j < 42; j++) begin
      new_dets();
      reg_write(int'(CORNER[j][11:8]), CORNER[j][7:0]);
      check_all();
    end
    // software keeps reserved bits at zero, hence the masks
    for (int i = 0; i < 40; i++) begin
      new_dets();
      k = int'(lfsr_q[7:0]) % 6;
      reg_write(k, lfsr_q[15:8] & MASK_TAB[k]);
      if (i % 4 == 3) check_all();
    end
    check_all();
    bus_xfer(1'b0, 8'h00, 32'h0, 4'hF, rd, rs);
    chk_bus(rd, rs, 32'h0, 2'h2);
    bus_xfer(1'b1, 8'hA0, 32'hFF, 4'h1, rd, rs);
    chk(rs, 2'h2);
    bus_xfer(1'b1, {IDX_TAB[2][5:0], 2'b00}, 32'h55, 4'h0, rd, rs);
    chk(rs, 2'h0);
    check_all();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (mdl[j]) mdl[j] = RST_TAB[j];
    check_all();
    finish_test();
  end
endmodule
